/* File: verilog/sflash_dev.sv */
`timescale 1ns/1ps
module sflash_dev #(
  parameter int SECTOR_ERASE_CYC = sflash_pkg::SECTOR_ERASE_CYC,
  parameter int CHIP_ERASE_CYC   = sflash_pkg::CHIP_ERASE_CYC,
  parameter int PROG_BYTE_CYC    = sflash_pkg::PROG_BYTE_CYC,
  parameter int PROG_PAGE_CYC    = sflash_pkg::PROG_PAGE_CYC,
  parameter int STATUS_WRITE_CYC = sflash_pkg::STATUS_WRITE_CYC,
  parameter int POWERUP_CYC      = sflash_pkg::POWERUP_CYC,
  parameter int TIME_LIMIT_CYC   = sflash_pkg::CHIP_ERASE_CYC
) (
  input  wire logic     clk_in,          // System clock
  input  wire logic     arst_n_in,       // Async reset, low active
  sflash_if.device      link,            // Serial link
  input  wire logic     fault_in,        // Forces the next operation to overrun
  output logic [7:0]    status_out,      // Status byte
  output logic          paused_out,      // Pause state
  output logic          por_done_out     // Power-up lockout over
);

  typedef enum logic [1:0] {IDLE, BUSY, LOCKED} op_state_t;

  // ==========================================================================
  // Synchronisers
  logic [1:0] sel_s_r, sck_s_r, mosi_s_r, hold_s_r;
  logic       sck_d_r, sel_d_r;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sel_s_r  <= 2'h3;
      sck_s_r  <= 2'h0;
      mosi_s_r <= 2'h0;
      hold_s_r <= 2'h3;
      sck_d_r  <= 1'b0;
      sel_d_r  <= 1'b1;
    end else begin
      sel_s_r  <= {sel_s_r[0], link.sel_n};
      sck_s_r  <= {sck_s_r[0], link.sck};
      mosi_s_r <= {mosi_s_r[0], link.mosi};
      hold_s_r <= {hold_s_r[0], link.hold_n};
      sck_d_r  <= sck_s_r[1];
      sel_d_r  <= sel_s_r[1];
    end
  end

  wire sel_n   = sel_s_r[1];
  wire sck     = sck_s_r[1];
  wire sel_rise = sel_n & ~sel_d_r;

  // Pause state: entered and left while clock low, select low
  logic paused_r, paused_nxt;
  assign paused_nxt = sel_n ? 1'b0 : (~sck ? ~hold_s_r[1] : paused_r);

  // Serial edges only count when selected and not paused
  wire sck_rise = sck & ~sck_d_r & ~sel_n & ~paused_r;
  wire sck_fall = ~sck & sck_d_r & ~sel_n & ~paused_r;

  // ==========================================================================
  // Shifter and decoder
  logic [7:0]  shift_r, opcode_r, out_r;
  logic [2:0]  bit_cnt_r;
  logic [9:0]  byte_cnt_r;       // Bytes shifted in this frame
  logic        op_valid_r;
  logic        miso_oe_r;
  logic        miso_r;
  wire  [7:0]  shift_next = {shift_r[6:0], mosi_s_r[1]};
  wire         byte_done  = sck_rise & (bit_cnt_r == 3'h7);

  // Operation control
  op_state_t   state_r;
  logic [31:0] timer_r;
  logic [31:0] busy_len_r;
  logic        wel_r, err_r, fault_r;
  logic [31:0] por_cnt_r;
  logic        por_done_r;
  logic        pwr_down_r;

  wire busy     = (state_r != IDLE);
  wire [7:0] status = {2'h0, err_r, 3'h0, wel_r, busy};

  // Commands launched on the select rise only
  wire op_done1 = op_valid_r & (byte_cnt_r == 10'd1);
  wire do_reset = sel_rise & op_done1 & (opcode_r == sflash_pkg::OP_SWRESET);
  wire can_wr   = sel_rise & wel_r & ~busy & por_done_r & ~pwr_down_r;
  wire do_chip  = can_wr & op_done1 & (opcode_r == sflash_pkg::OP_CHIP_ERS);
  wire do_sect  = can_wr & op_valid_r & (byte_cnt_r == 10'd4) & (opcode_r == sflash_pkg::OP_SECT_ERS);
  wire do_wrsr  = can_wr & op_valid_r & (byte_cnt_r == 10'd2) & (opcode_r == sflash_pkg::OP_WRSR);
  wire do_prog  = can_wr & op_valid_r & (byte_cnt_r > 10'd4) & (opcode_r == sflash_pkg::OP_PROG);
  wire [9:0] prog_bytes = (byte_cnt_r - 10'd4 > 10'd256) ? 10'd256 : byte_cnt_r - 10'd4;
  wire [31:0] prog_len  = (prog_bytes <= 10'(sflash_pkg::PROG_SHORT_MAX_BYTES))
                          ? 32'(PROG_BYTE_CYC) * {22'h0, prog_bytes} : 32'(PROG_PAGE_CYC);
  wire [31:0] start_len = do_chip ? 32'(CHIP_ERASE_CYC) :
                          do_sect ? 32'(SECTOR_ERASE_CYC) :
                          do_wrsr ? 32'(STATUS_WRITE_CYC) : prog_len;
  wire start_op = do_chip | do_sect | do_wrsr | do_prog;
  // Real cells never overrun here, so fault_in stands in for a worn cell; the timer then
  // runs past the normal length up to the limit and the sequencer locks
  wire op_end   = (state_r == BUSY) & (timer_r + 32'h1 >= busy_len_r);
  wire op_limit = (state_r == BUSY) & fault_r & (timer_r + 32'h1 >= 32'(TIME_LIMIT_CYC));

  // Shift register, bit and byte counters; the counters reset on select high
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      shift_r    <= 8'h00;
      bit_cnt_r  <= 3'h0;
      byte_cnt_r <= 10'h0;
      opcode_r   <= 8'h00;
      op_valid_r <= 1'b0;
      paused_r   <= 1'b0;
    end else begin
      paused_r <= paused_nxt;
      if (sel_n) begin
        bit_cnt_r  <= 3'h0;
        if (!sel_rise) begin
          byte_cnt_r <= 10'h0;
          op_valid_r <= 1'b0;
        end
      end else if (sck_rise) begin
        shift_r   <= shift_next;
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (byte_done) begin
          if (byte_cnt_r != 10'h3FF) byte_cnt_r <= byte_cnt_r + 10'h1;
          if (byte_cnt_r == 10'h0) begin
            opcode_r   <= shift_next;
            op_valid_r <= 1'b1;
          end
        end
      end
    end
  end

  // Read-back shifter; protection bits are not modelled, so the status write byte is not kept
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      out_r       <= 8'h00;
      miso_r      <= 1'b0;
      miso_oe_r   <= 1'b0;
    end else begin
      miso_oe_r <= ~sel_n & ~paused_nxt & op_valid_r & (opcode_r == sflash_pkg::OP_RDSR);
      if (byte_done) out_r <= status;
      else if (sck_fall) begin
        miso_r <= out_r[7];
        out_r  <= {out_r[6:0], 1'b0};
      end
    end
  end

  // Operation sequencer, error flag and write-enable latch
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r    <= IDLE;
      timer_r    <= 32'h0;
      busy_len_r <= 32'h0;
      wel_r      <= 1'b0;     // Latch clear at power-up
      err_r      <= 1'b0;
      fault_r    <= 1'b0;
      por_cnt_r  <= 32'h0;
      por_done_r <= 1'b0;
      pwr_down_r <= 1'b0;
    end else begin
      // Power-on lockout counter
      if (!por_done_r) begin
        por_cnt_r <= por_cnt_r + 32'h1;
        if (por_cnt_r + 32'h1 >= 32'(POWERUP_CYC)) por_done_r <= 1'b1;
      end
      if (do_reset) begin
        state_r <= IDLE;
        err_r   <= 1'b0;
        fault_r <= 1'b0;
        wel_r   <= 1'b0;
      end else if (start_op) begin
        state_r    <= BUSY;
        timer_r    <= 32'h0;
        busy_len_r <= start_len;
        fault_r    <= fault_in;
      end else if (op_limit) begin
        state_r <= LOCKED;              // Stays busy until reset
        err_r   <= 1'b1;
      end else if (op_end & ~fault_r) begin
        state_r <= IDLE;
        wel_r   <= 1'b0;
      end else begin
        if (state_r == BUSY) timer_r <= timer_r + 32'h1;
        // One-byte latch and power-down commands are refused while busy (wake is not), so a running write keeps its state
        if (sel_rise & op_done1 & ~busy & por_done_r) begin
          if (opcode_r == sflash_pkg::OP_WREN && !pwr_down_r) wel_r <= 1'b1;
          if (opcode_r == sflash_pkg::OP_WRDI && !pwr_down_r) wel_r <= 1'b0;
          if (opcode_r == sflash_pkg::OP_PWR_DOWN) pwr_down_r <= 1'b1;
        end
        if (sel_rise & op_done1 & (opcode_r == sflash_pkg::OP_WAKE)) pwr_down_r <= 1'b0;
      end
    end
  end

  // Outputs from flip-flops
  assign link.miso_o  = miso_r;
  assign link.miso_oe = miso_oe_r;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      status_out   <= 8'h00;
      paused_out   <= 1'b0;
      por_done_out <= 1'b0;
    end else begin
      status_out   <= status;
      paused_out   <= paused_r;
      por_done_out <= por_done_r;
    end
  end

endmodule

/* File: verilog/sflash_pkg.sv */
// Functional notes
// - Reset opcode is one byte, nothing follows
// - Reset applied only at select rise
// - Reset clears the time-excess error flag
// - Timed-out operation stays busy until reset
// - Pause pin fall with clock low pauses
// - Pause pin rise with clock low resumes
// - Host changes pause only while clock low
// - Pause needs select low; select rise ends
// - While paused output floats, inputs ignored
// - Power-on reset blocks writes during power-up
// - Status write completion clears write enable
// - Erase completion clears write enable
// - Host waits power-up interval before access; the testbench sends its first enable inside it
// - Sector and chip erase busy durations
// - Page program busy per byte or total
// - Status write busy duration
// - Host waits wake recovery after release
// - Error flag is status bit five
// - Write enable is bit one, gates writes
package sflash_pkg;

  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OP_WREN     = 8'h06;
  localparam logic [7:0] OP_WRDI     = 8'h04;
  localparam logic [7:0] OP_RDSR     = 8'h05;
  localparam logic [7:0] OP_WRSR     = 8'h01;
  localparam logic [7:0] OP_SECT_ERS = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERS = 8'hC7;
  localparam logic [7:0] OP_PROG     = 8'h02;
  localparam logic [7:0] OP_SWRESET  = 8'hFF;
  localparam logic [7:0] OP_PWR_DOWN = 8'hB9;
  localparam logic [7:0] OP_WAKE     = 8'hAB;

  // ==========================================================================
  // Status bit positions
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_WEL_BIT   = 1;
  localparam int ST_ERROR_BIT = 5;

  // ==========================================================================
  // Timing, real units and derived cycle counts at 50 MHz
  localparam int CLK_MHZ                       = 50;
  localparam int SECTOR_ERASE_DURATION_US      = 500000;   // Max 0.5 s
  localparam int CHIP_ERASE_DURATION_US        = 5000000;  // Max 5 s
  localparam int PAGE_PROGRAM_BYTE_US          = 50;       // Per byte up to 32
  localparam int PAGE_PROGRAM_DURATION_US      = 2500;     // Max 2.5 ms
  localparam int STATUS_WRITE_DURATION_US      = 15000;    // Max 15 ms
  localparam int POWERUP_WRITE_DELAY_US        = 10000;    // 10 ms
  localparam int WAKE_RECOVERY_TIME_NS         = 25;
  localparam int PROG_SHORT_MAX_BYTES          = 32;
  localparam int SECTOR_ERASE_CYC  = SECTOR_ERASE_DURATION_US * CLK_MHZ;
  localparam int CHIP_ERASE_CYC    = CHIP_ERASE_DURATION_US * CLK_MHZ;
  localparam int PROG_BYTE_CYC     = PAGE_PROGRAM_BYTE_US * CLK_MHZ;
  localparam int PROG_PAGE_CYC     = PAGE_PROGRAM_DURATION_US * CLK_MHZ;
  localparam int STATUS_WRITE_CYC  = STATUS_WRITE_DURATION_US * CLK_MHZ;
  localparam int POWERUP_CYC       = POWERUP_WRITE_DELAY_US * CLK_MHZ;
  localparam int WAKE_RECOVERY_CYC = (WAKE_RECOVERY_TIME_NS * CLK_MHZ + 999) / 1000;

  // Host link clock divider: half period in system cycles (160 ns period)
  localparam int SCK_HALF_CYC = 4;

endpackage

/* File: verilog/sflash_if.sv */
`timescale 1ns/1ps
// Serial link between host controller and flash device
interface sflash_if;
  logic sel_n;       // Chip select, low active
  logic sck;         // Serial clock
  logic mosi;        // Host to device data
  logic hold_n;      // Pause pin, low active
  logic miso_o;      // Device data out
  logic miso_oe;     // Device output enable
  wire  miso = miso_oe ? miso_o : 1'b1;  // Weak pull-up when floated

  modport device (input sel_n, sck, mosi, hold_n, output miso_o, miso_oe);
  modport host   (output sel_n, sck, mosi, hold_n, input miso);
endinterface

/* File: verilog/sflash_host.sv */
`timescale 1ns/1ps
module sflash_host (
  input  wire logic       clk_in,       // System clock
  input  wire logic       arst_n_in,    // Async reset, low active
  sflash_if.host          link,         // Serial link
  input  wire logic       start_in,     // Start a frame, pulse
  input  wire logic [7:0] nbytes_in,    // Bytes in frame, at least 1
  input  wire logic [7:0] tx_in,        // Byte to send
  output logic            tx_req_out,   // Next tx byte taken, pulse
  output logic [7:0]      rx_out,       // Received byte
  output logic            rx_vld_out,   // Received byte valid, pulse
  input  wire logic       pause_in,     // Request pause
  output logic            busy_out      // Frame in progress
);

  // ==========================================================================
  // Link side flops; host makes the clock by dividing clk_in
  logic       sel_n_r, sck_r, mosi_r, hold_n_r;
  logic [7:0] txsh_r, rxsh_r, left_r;
  logic [2:0] bit_r;
  logic [2:0] div_r;
  logic [1:0] miso_s_r;
  logic       run_r;
  logic [3:0] gap_r;        // Deselect cycles still owed after a frame
  wire        tick = (div_r == 3'(sflash_pkg::SCK_HALF_CYC - 1));
  // A pause request still lets a high clock fall, so the pause pin only ever moves with the clock low
  wire        step    = tick && hold_n_r && (sck_r || !pause_in);
  wire  [7:0] rx_next = {rxsh_r[6:0], miso_s_r[1]};

  assign link.sel_n  = sel_n_r;
  assign link.sck    = sck_r;
  assign link.mosi   = mosi_r;
  assign link.hold_n = hold_n_r;

  // Sequencer; pause pin changes only with clock low
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sel_n_r <= 1'b1; sck_r <= 1'b0; mosi_r <= 1'b0; hold_n_r <= 1'b1;
      txsh_r <= 8'h00; rxsh_r <= 8'h00; left_r <= 8'h00; bit_r <= 3'h0;
      div_r <= 3'h0; miso_s_r <= 2'h0; run_r <= 1'b0;
      gap_r <= 4'h0;
      tx_req_out <= 1'b0; rx_out <= 8'h00; rx_vld_out <= 1'b0; busy_out <= 1'b0;
    end else begin
      miso_s_r   <= {miso_s_r[0], link.miso};
      tx_req_out <= 1'b0;
      rx_vld_out <= 1'b0;
      div_r      <= tick ? 3'h0 : div_r + 3'h1;
      if (!sck_r && tick) hold_n_r <= ~pause_in;
      if (!run_r) begin
        if (gap_r != 4'h0) begin
          gap_r <= gap_r - 4'h1;  // Select stays high for the recovery time
        end else if (start_in && nbytes_in != 8'h00) begin
          run_r <= 1'b1; busy_out <= 1'b1; sel_n_r <= 1'b0;
          left_r <= nbytes_in; txsh_r <= tx_in; mosi_r <= tx_in[7];
          tx_req_out <= 1'b1; bit_r <= 3'h0;
        end else begin
          sel_n_r <= 1'b1; busy_out <= 1'b0;
        end
      end else if (step) begin
        if (left_r == 8'h00) begin
          run_r <= 1'b0; sel_n_r <= 1'b1;  // Frame end; select rise launches command
          gap_r <= 4'(sflash_pkg::WAKE_RECOVERY_CYC);
        end else if (!sck_r) begin
          sck_r  <= 1'b1;
        end else begin
          // Sampled at the fall: the round trip through both synchronisers exceeds half a period
          sck_r  <= 1'b0;
          rxsh_r <= rx_next;
          bit_r  <= bit_r + 3'h1;
          if (bit_r == 3'h7) begin
            left_r <= left_r - 8'h1; rx_out <= rx_next; rx_vld_out <= 1'b1;
            if (left_r != 8'h1) begin
              txsh_r <= tx_in; mosi_r <= tx_in[7]; tx_req_out <= 1'b1;
            end
          end else begin
            txsh_r <= {txsh_r[6:0], 1'b0}; mosi_r <= txsh_r[6];
          end
        end
      end
    end
  end

endmodule

/* File: sim/sflash_props.sv */
`timescale 1ns/1ps
module sflash_props (
  input wire logic clk_in,    // System clock
  input wire logic arst_n_in, // Async reset, low active
  input wire logic sel_n,     // Select, low active
  input wire logic sck,       // Link clock
  input wire logic mosi,      // Host data
  input wire logic hold_n,    // Pause pin, low active
  input wire logic miso_oe    // Device output enable
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  // ==========================================================================
  // Host end: link clock shape and pause timing
  hold_clk_low_a: assert property ($changed(hold_n) |-> !sck && !$past(sck))
    else $error("pause pin moved while link clock high");
  sck_half_a: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
    else $error("link clock high phase not four cycles");
  sck_idle_a: assert property (sel_n && $past(sel_n) |-> !sck)
    else $error("link clock moves while deselected");
  mosi_steady_a: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("host data changed in clock high phase");
  pause_sck_a: assert property (!hold_n && !sel_n |-> !sck)
    else $error("link clock high during pause");

  // ==========================================================================
  // Device end: output floats while paused or deselected
  pause_float_a: assert property ((!sel_n && !hold_n) [*4] |-> !miso_oe)
    else $error("device drives output while paused");
  desel_float_a: assert property (sel_n [*4] |-> !miso_oe)
    else $error("device drives output while deselected");
  oe_cause_a: assert property ($rose(miso_oe) |-> !$past(sel_n, 2) && $past(hold_n, 2))
    else $error("output enabled without select or during pause");

  // Main scenarios reached
  cover property (!hold_n && !sel_n);
  cover property ($rose(miso_oe));
  cover property ($rose(sel_n));
endmodule

/* File: sim/spi_flash_reset_hold_control_tb_top.sv */
`timescale 1ns/1ps
module spi_flash_reset_hold_control_tb_top;
  // Short counts keep the run small; expectations derive from them
  localparam int SE_CYC = 300;
  localparam int CE_CYC = 400;
  localparam int PB_CYC = 5;
  localparam int PP_CYC = 250;
  localparam int SW_CYC = 200;
  localparam int POR_CYC = 200;
  localparam int TL_CYC = 500;
  logic       clk_in, arst_n_in, start_in, pause_in, fault_in;
  logic       tx_req, rx_vld, hbusy, paused, por_done;
  logic [7:0] nbytes_in, tx_in, rx, status, rx_last, mid_stat;
  logic [7:0] b [$];
  int         failures, n_tests, seed, cyc, pause_at, t, n, e;

  sflash_if link ();
  sflash_dev #(.SECTOR_ERASE_CYC(SE_CYC), .CHIP_ERASE_CYC(CE_CYC), .PROG_BYTE_CYC(PB_CYC),
    .PROG_PAGE_CYC(PP_CYC), .STATUS_WRITE_CYC(SW_CYC), .POWERUP_CYC(POR_CYC),
    .TIME_LIMIT_CYC(TL_CYC)) sflash_dev_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .link(link), .fault_in(fault_in), .status_out(status), .paused_out(paused), .por_done_out(por_done));
  sflash_host sflash_host_i (.clk_in(clk_in), .arst_n_in(arst_n_in), .link(link), .start_in(start_in),
    .nbytes_in(nbytes_in), .tx_in(tx_in), .tx_req_out(tx_req), .rx_out(rx), .rx_vld_out(rx_vld),
    .pause_in(pause_in), .busy_out(hbusy));
  sflash_props sflash_props_i (.clk_in(clk_in), .arst_n_in(arst_n_in), .sel_n(link.sel_n),
    .sck(link.sck), .mosi(link.mosi), .hold_n(link.hold_n), .miso_oe(link.miso_oe));

  // ==========================================================================
  // Clock, hang guard and received byte capture
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (rx_vld === 1'b1) rx_last <= rx;
    if (cyc == 30000) begin
      failures++;
      close_out();
    end
  end

  // ==========================================================================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Sends one frame; the next byte is always presented ahead of the host's request
  task automatic send(input logic [7:0] q [$]);
    int i, k;
    i = 0;
    @(posedge clk_in);
    start_in <= 1'b1;
    nbytes_in <= 8'(q.size());
    tx_in <= q[0];
    @(posedge clk_in);
    start_in <= 1'b0;
    if (q.size() > 1) tx_in <= q[1];
    for (k = 0; k < 6000 && (k < 3 || hbusy === 1'b1); k++) begin
      @(posedge clk_in);
      if (k == 40) mid_stat = status;
      if (k == pause_at) pause_in <= 1'b1;
      if (k == pause_at + 30) pause_in <= 1'b0;
      if (k == pause_at + 25) check("paused", 1, paused);
      if (k == pause_at + 25) check("output enable in pause", 0, link.miso_oe);
      if (k == pause_at + 42) check("pause released", 0, paused);
      if (tx_req === 1'b1) begin
        i++;
        if (i < q.size()) tx_in <= q[i];
      end
    end
    repeat (6) @(posedge clk_in);
  endtask

  // Busy was raised a few cycles before the frame task returned
  task automatic busy_for(input int exp);
    int c;
    c = 0;
    while (status[sflash_pkg::ST_BUSY_BIT] === 1'b1 && c < exp + 50) begin
      @(posedge clk_in);
      c++;
    end
    check("busy length in range", 1, (c + 12 >= exp) && (c <= exp + 2));
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    seed = 91;
    failures = 0;
    n_tests = 0;
    cyc = 0;
    pause_at = 9999;
    arst_n_in = 1'b0;
    start_in = 1'b0;
    nbytes_in = 8'h01;
    tx_in = 8'h00;
    pause_in = 1'b0;
    fault_in = 1'b0;
    repeat (8) @(posedge clk_in);
    arst_n_in <= 1'b1;
    // Enable attempted inside the power-up lockout
    send('{sflash_pkg::OP_WREN});
    check("enable during power-up", 0, status[sflash_pkg::ST_WEL_BIT]);
    for (n = 0; n < POR_CYC && por_done !== 1'b1; n++) @(posedge clk_in);
    check("power-up done", 1, por_done);
    // Pause held while deselected must not take effect
    pause_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    check("pause while deselected", 0, paused);
    pause_in <= 1'b0;
    // Pause in mid-byte; the command must still complete intact
    pause_at = 20;
    send('{sflash_pkg::OP_WREN});
    pause_at = 9999;
    check("enable after paused frame", 1, status[sflash_pkg::ST_WEL_BIT]);
    // Power-down ignores the disable until the wake command
    send('{sflash_pkg::OP_PWR_DOWN});
    send('{sflash_pkg::OP_WRDI});
    check("disable in power-down", 1, status[sflash_pkg::ST_WEL_BIT]);
    send('{sflash_pkg::OP_WAKE});
    send('{sflash_pkg::OP_WRDI});
    check("disable after wake", 0, status[sflash_pkg::ST_WEL_BIT]);
    // Every write kind, including both program boundaries
    for (t = 0; t < 6; t++) begin
      send('{sflash_pkg::OP_WREN});
      check("enable latch set", 1, status[sflash_pkg::ST_WEL_BIT]);
      case (t)
        0: begin
          b = '{sflash_pkg::OP_WRSR, 8'($random(seed))};
          e = SW_CYC;
        end
        1: begin
          b = '{sflash_pkg::OP_SECT_ERS, 8'($random(seed)), 8'($random(seed)), 8'($random(seed))};
          e = SE_CYC;
        end
        2: begin
          b = '{sflash_pkg::OP_CHIP_ERS};
          e = CE_CYC;
        end
        default: begin
          n = (t == 3) ? 1 + ($random(seed) & 31) : (t == 4) ? 32 : 33;
          b = '{sflash_pkg::OP_PROG, 8'($random(seed)), 8'($random(seed)), 8'($random(seed))};
          repeat (n) b.push_back(8'($random(seed)));
          e = (n <= 32) ? n * PB_CYC : PP_CYC;
        end
      endcase
      send(b);
      busy_for(e);
      check("enable latch after write", 0, status[sflash_pkg::ST_WEL_BIT]);
    end
    // Erase without the enable latch is refused
    send('{sflash_pkg::OP_WRDI});
    send('{sflash_pkg::OP_SECT_ERS, 8'h01, 8'h00, 8'h00});
    check("busy without enable", 0, status[sflash_pkg::ST_BUSY_BIT]);
    // Overrun locks the device busy until the reset opcode
    fault_in <= 1'b1;
    send('{sflash_pkg::OP_WREN});
    send('{sflash_pkg::OP_SECT_ERS, 8'h02, 8'h00, 8'h00});
    fault_in <= 1'b0;
    repeat (SE_CYC + TL_CYC + 50) @(posedge clk_in);
    check("locked busy", 1, status[sflash_pkg::ST_BUSY_BIT]);
    check("error flag", 1, status[sflash_pkg::ST_ERROR_BIT]);
    send('{sflash_pkg::OP_RDSR, 8'h00});
    check("read status error and busy", 2'b11, {rx_last[5], rx_last[0]});
    send('{sflash_pkg::OP_SWRESET});
    check("error kept while selected", 1, mid_stat[sflash_pkg::ST_ERROR_BIT]);
    check("busy after reset", 0, status[sflash_pkg::ST_BUSY_BIT]);
    check("error after reset", 0, status[sflash_pkg::ST_ERROR_BIT]);
    close_out();
  end
endmodule
